/* logic/microstep_wave_table_defs.vh */
`ifndef MICROSTEP_WAVE_TABLE_DEFS_VH
`define MICROSTEP_WAVE_TABLE_DEFS_VH

// ==========================================================
// Register byte offsets
`define OFS_DELTA_WORD_0   8'h00
`define OFS_DELTA_WORD_7   8'h1C
`define OFS_SEGMENT_CONFIG 8'h20
`define OFS_START_VALUES   8'h24
`define OFS_RESOLUTION     8'h28
`define OFS_POSITION       8'h2C
`define OFS_CURRENT_AXIS0  8'h30
`define OFS_CURRENT_AXIS1  8'h34

// ==========================================================
// Segment configuration fields
`define SLOPE_0_LSB      0
`define SLOPE_1_LSB      2
`define SLOPE_2_LSB      4
`define SLOPE_3_LSB      6
`define BOUNDARY_1_LSB   8
`define BOUNDARY_2_LSB   16
`define BOUNDARY_3_LSB   24

// ==========================================================
// Start value fields
`define START_A_LSB      0
`define START_B_LSB      16

// ==========================================================
// Reset values
`define RST_DELTA_WORD_0   32'hAAAAB554
`define RST_DELTA_WORD_1   32'h4A9554AA
`define RST_DELTA_WORD_2   32'h24492929
`define RST_DELTA_WORD_3   32'h10104222
`define RST_DELTA_WORD_4   32'hFBFFFFFF
`define RST_DELTA_WORD_5   32'hB5BB777D
`define RST_DELTA_WORD_6   32'h49295556
`define RST_DELTA_WORD_7   32'h00404222
`define RST_SEGMENT_CONFIG 32'hFFFF8056
`define RST_START_VALUES   32'h00F70000
`define RST_RESOLUTION     32'h00000000

// ==========================================================
// Step width shift limit and the quarter shift for coil B
`define MAX_RES_SHIFT      4'h8
`define QUARTER_SHIFT      10'h100

`endif

/* logic/microstep_wave_table.v */
`include "microstep_wave_table_defs.vh"
`default_nettype none

// How it works
// - Only the 0 to 90 degree quarter is stored; the rest is mirrored.
// - A 10-bit position counter addresses the extended 1024-entry wave.
// - The quarter is 256 one-bit deltas held in eight 32-bit words.
// - Each table advance adds segment slope, plus one when the delta bit is set.
// - Segment slopes are coded as minus one, zero, one or two.
// - Three boundaries split the quarter into four slope segments.
// - Every microstep recomputes coil A and coil B values into readable registers.
// - Both coil values reload from start values whenever the counter reaches zero.
// - The first start value initialises coil A at position zero.
// - The second start value initialises coil B, the 90 degree shifted wave.
// - One table serves both motor axes.
// - After reset the table holds a sine wave.
// - The wave spans 1024 entries; resolution selects the step width.
// - Each step pulse taken while idle moves the counter by the width, up or down by direction; pulses while busy are ignored.
// - Full resolution moves one entry, half moves two, coarser settings double up to a maximum of 256 entries.
// - Resolution may change anytime without disturbing the counter position.
module microstep_wave_table (
  input wire clock_in,
  input wire sys_rst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [31:0] paddr_in,
  input wire [31:0] pwdata_in,
  output wire [31:0] prdata_out,
  output wire pready_out,
  output wire pslverr_out,
  input wire [1:0] step_in,
  input wire [1:0] dir_in,
  output wire [1:0] busy_out,
  output wire [19:0] microstep_position_counter_out,
  output wire [17:0] coil_a_current_value_out,
  output wire [17:0] coil_b_current_value_out
);

  // ==========================================================
  // Functions
  function [31:0] default_word;
    input [2:0] idx;
    begin
      case (idx)
        3'h0: default_word = `RST_DELTA_WORD_0;
        3'h1: default_word = `RST_DELTA_WORD_1;
        3'h2: default_word = `RST_DELTA_WORD_2;
        3'h3: default_word = `RST_DELTA_WORD_3;
        3'h4: default_word = `RST_DELTA_WORD_4;
        3'h5: default_word = `RST_DELTA_WORD_5;
        3'h6: default_word = `RST_DELTA_WORD_6;
        default: default_word = `RST_DELTA_WORD_7;
      endcase
    end
  endfunction

  function is_mapped;
    input [31:0] addr;
    begin
      is_mapped = (addr[31:8] == 24'h000000) && (addr[1:0] == 2'h0) && (addr[7:0] <= `OFS_CURRENT_AXIS1);
    end
  endfunction

  // Quarter index of a full-wave position
  function [7:0] quarter_index;
    input [9:0] pos;
    begin
      quarter_index = pos[8] ? ~pos[7:0] : pos[7:0];
    end
  endfunction

  // Increment applied when stepping out of entry k
  function signed [8:0] entry_delta;
    input [7:0] k;
    input [255:0] tbl;
    input [31:0] cfg;
    reg [1:0] w;
    begin
      if (k < cfg[`BOUNDARY_1_LSB +: 8]) begin
        w = cfg[`SLOPE_0_LSB +: 2];
      end else if (k < cfg[`BOUNDARY_2_LSB +: 8]) begin
        w = cfg[`SLOPE_1_LSB +: 2];
      end else if (k < cfg[`BOUNDARY_3_LSB +: 8]) begin
        w = cfg[`SLOPE_2_LSB +: 2];
      end else begin
        w = cfg[`SLOPE_3_LSB +: 2];
      end
      entry_delta = $signed({7'h00, w}) + $signed({8'h00, tbl[k]}) - 9'sh001;
    end
  endfunction

  // Magnitude after moving one entry from position a to b
  function signed [8:0] step_mag;
    input signed [8:0] mag;
    input [9:0] a;
    input [9:0] b;
    input [255:0] tbl;
    input [31:0] cfg;
    reg [7:0] ia;
    reg [7:0] ib;
    begin
      ia = quarter_index(a);
      ib = quarter_index(b);
      if (ib == ia + 8'h01) begin
        step_mag = mag + entry_delta(ia, tbl, cfg);
      end else if (ib + 8'h01 == ia) begin
        step_mag = mag - entry_delta(ib, tbl, cfg);
      end else begin
        step_mag = mag;
      end
    end
  endfunction

  function [8:0] step_width;
    input [3:0] res;
    begin
      if (res > `MAX_RES_SHIFT) begin
        step_width = 9'h100;
      end else begin
        step_width = 9'h001 << res;
      end
    end
  endfunction

  // ==========================================================
  // Configuration registers
  reg [31:0] delta_word_r [0:7];
  reg [31:0] segment_config_r;
  reg [31:0] start_values_r;
  reg [31:0] resolution_r;
  reg pready_r;
  reg pslverr_r;
  reg [31:0] prdata_r;
  reg [31:0] read_nxt;
  wire [255:0] table_bits;
  wire [19:0] pos_all;
  wire [17:0] coil_a_current_value_all;
  wire [17:0] coil_b_current_value_all;
  wire [1:0] busy_all;
  wire access_first;
  wire write_commit;
  wire [8:0] start_a;
  wire [8:0] start_b;
  integer i;

  assign access_first = psel_in & penable_in & ~pready_r;
  assign write_commit = psel_in & penable_in & pready_r & pwrite_in & is_mapped(paddr_in);
  assign start_a = {1'b0, start_values_r[`START_A_LSB +: 8]};
  assign start_b = {1'b0, start_values_r[`START_B_LSB +: 8]};

  genvar wd;
  generate
    for (wd = 0; wd < 8; wd = wd + 1) begin : flatten
      assign table_bits[32 * wd +: 32] = delta_word_r[wd];
    end
  endgenerate

  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      for (i = 0; i < 8; i = i + 1) begin
        delta_word_r[i] <= default_word(i[2:0]);
      end
      segment_config_r <= `RST_SEGMENT_CONFIG;
      start_values_r <= `RST_START_VALUES;
      resolution_r <= `RST_RESOLUTION;
    end else if (write_commit) begin
      if (paddr_in[7:0] <= `OFS_DELTA_WORD_7) begin
        delta_word_r[paddr_in[4:2]] <= pwdata_in;
      end
      if (paddr_in[7:0] == `OFS_SEGMENT_CONFIG) begin
        segment_config_r <= pwdata_in;
      end
      if (paddr_in[7:0] == `OFS_START_VALUES) begin
        start_values_r <= pwdata_in;
      end
      if (paddr_in[7:0] == `OFS_RESOLUTION) begin
        resolution_r <= {24'h000000, pwdata_in[7:0]};
      end
    end
  end

  // ==========================================================
  // APB answer
  always @* begin
    read_nxt = 32'h00000000;
    case (paddr_in[7:0])
      `OFS_RESOLUTION: read_nxt = resolution_r;
      `OFS_POSITION: read_nxt = {6'h00, pos_all[19:10], 6'h00, pos_all[9:0]};
      `OFS_CURRENT_AXIS0: read_nxt = {7'h00, coil_b_current_value_all[8:0], 7'h00, coil_a_current_value_all[8:0]};
      `OFS_CURRENT_AXIS1: read_nxt = {7'h00, coil_b_current_value_all[17:9], 7'h00, coil_a_current_value_all[17:9]};
      default: read_nxt = 32'h00000000;
    endcase
  end

  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= access_first;
      if (access_first) begin
        pslverr_r <= ~is_mapped(paddr_in);
        prdata_r <= (pwrite_in || !is_mapped(paddr_in)) ? 32'h00000000 : read_nxt;
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Per-axis sequencers sharing one table
  genvar ax;
  generate
    for (ax = 0; ax < 2; ax = ax + 1) begin : axis
      reg [9:0] pos_r;
      reg [8:0] rem_r;
      reg dir_r;
      reg busy_r;
      reg signed [8:0] mag_a_r;
      reg signed [8:0] mag_b_r;
      reg signed [8:0] coil_a_current_value_r;
      reg signed [8:0] coil_b_current_value_r;
      wire [9:0] pos_nxt;
      wire [9:0] pos_b;
      wire [9:0] pos_b_nxt;
      wire signed [8:0] mag_a_nxt;
      wire signed [8:0] mag_b_nxt;

      assign pos_nxt = dir_r ? pos_r - 10'h001 : pos_r + 10'h001;
      assign pos_b = pos_r + `QUARTER_SHIFT;
      assign pos_b_nxt = pos_nxt + `QUARTER_SHIFT;
      assign mag_a_nxt = (pos_nxt == 10'h000) ? $signed(start_a) :
        step_mag(mag_a_r, pos_r, pos_nxt, table_bits, segment_config_r);
      assign mag_b_nxt = (pos_nxt == 10'h000) ? $signed(start_b) :
        step_mag(mag_b_r, pos_b, pos_b_nxt, table_bits, segment_config_r);

      always @(posedge clock_in) begin
        if (sys_rst_in) begin
          pos_r <= 10'h000;
          rem_r <= 9'h000;
          dir_r <= 1'b0;
          busy_r <= 1'b0;
          mag_a_r <= 9'sh000;
          mag_b_r <= 9'sh0F7;
          coil_a_current_value_r <= 9'sh000;
          coil_b_current_value_r <= 9'sh0F7;
        end else if (rem_r != 9'h000) begin
          pos_r <= pos_nxt;
          rem_r <= rem_r - 9'h001;
          busy_r <= (rem_r != 9'h001);
          mag_a_r <= mag_a_nxt;
          mag_b_r <= mag_b_nxt;
          coil_a_current_value_r <= pos_nxt[9] ? -mag_a_nxt : mag_a_nxt;
          coil_b_current_value_r <= pos_b_nxt[9] ? -mag_b_nxt : mag_b_nxt;
        end else if (step_in[ax]) begin
          rem_r <= step_width(resolution_r[4 * ax +: 4]);
          dir_r <= dir_in[ax];
          busy_r <= 1'b1;
        end
      end

      assign pos_all[10 * ax +: 10] = pos_r;
      assign coil_a_current_value_all[9 * ax +: 9] = coil_a_current_value_r;
      assign coil_b_current_value_all[9 * ax +: 9] = coil_b_current_value_r;
      assign busy_all[ax] = busy_r;
    end
  endgenerate

  // ==========================================================
  // Outputs
  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign busy_out = busy_all;
  assign microstep_position_counter_out = pos_all;
  assign coil_a_current_value_out = coil_a_current_value_all;
  assign coil_b_current_value_out = coil_b_current_value_all;

endmodule

`default_nettype wire

/* tb/microstep_wave_table_checker.sv */
`default_nettype none
// ==========================================
// Port checker
module microstep_wave_table_checker (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [31:0] paddr_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [1:0] step_in,
  input wire logic [1:0] busy_out,
  input wire logic [19:0] microstep_position_counter_out,
  input wire logic [17:0] coil_a_current_value_out
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic [9:0] pos0 = microstep_position_counter_out[9:0];
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_access;
    psel_in && penable_in && !pready_out;
  endsequence
  a_ready_follows: assert property (s_access |=> pready_out)
    else $error("no ready after access");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  a_err_unmapped: assert property (pready_out && paddr_in > 32'h34 |-> pslverr_out)
    else $error("unmapped access not flagged");
  a_busy_start: assert property (step_in[0] && !busy_out[0] |=> busy_out[0])
    else $error("step not taken");
  a_pos_idle: assert property (!busy_out[0] |=> $stable(pos0))
    else $error("position moved while idle");
  a_pos_unit: assert property (busy_out[0] |=> pos0 == $past(pos0) + 10'h001 || pos0 == $past(pos0) - 10'h001)
    else $error("position move not one entry");
  a_coil_idle: assert property (!busy_out[0] |=> $stable(coil_a_current_value_out[8:0]))
    else $error("coil value moved while idle");
  a_busy_bound: assert property ($rose(busy_out[0]) |-> ##[1:256] !busy_out[0])
    else $error("step walk too long");
endmodule
bind microstep_wave_table microstep_wave_table_checker i_chk (.clock_in, .sys_rst_in, .psel_in, .penable_in,
  .paddr_in, .pready_out, .pslverr_out, .step_in, .busy_out, .microstep_position_counter_out,
  .coil_a_current_value_out);
`default_nettype wire

/* tb/tb_microstep_wave_table.sv */
`include "microstep_wave_table_defs.vh"
`default_nettype none
// ==========================================
// Bench
module tb_microstep_wave_table;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [31:0] paddr_in = 32'h0;
  logic [31:0] pwdata_in = 32'h0;
  logic [1:0] step_in = 2'h0;
  logic [1:0] dir_in = 2'h0;
  wire logic [31:0] prdata_out;
  wire logic pready_out;
  wire logic pslverr_out;
  wire logic [1:0] busy_out;
  wire logic [19:0] pos;
  wire logic [17:0] coil_a_current_value;
  wire logic [17:0] coil_b_current_value;
  logic [31:0] q;
  logic e;
  int n_mismatch = 0;
  int tests_run = 0;
  int i;
  always #2.5 clock_in = ~clock_in;
  microstep_wave_table i_dut (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .step_in(step_in),
    .dir_in(dir_in),
    .busy_out(busy_out),
    .microstep_position_counter_out(pos),
    .coil_a_current_value_out(coil_a_current_value),
    .coil_b_current_value_out(coil_b_current_value)
  );
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      n_mismatch++;
    end
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clock_in);
      if (pready_out === 1'b1) break;
    end
    if (n == 20) begin
      n_mismatch++;
      stop_test;
    end
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task rd(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check("read data", q, exp);
  endtask
  task step(input int ax, input logic d, input int w);
    int n;
    int k;
    step_in[ax] <= 1'b1;
    dir_in[ax] <= d;
    @(posedge clock_in);
    step_in[ax] <= 1'b0;
    k = 0;
    for (n = 0; n < 300; n++) begin
      @(posedge clock_in);
      if (busy_out[ax] === 1'b0) break;
      k++;
    end
    if (n == 300) begin
      n_mismatch++;
      stop_test;
    end
    check("walk length", k, w);
  endtask
  task t_reset;
    rd(`OFS_RESOLUTION, `RST_RESOLUTION);
    rd(`OFS_CURRENT_AXIS0, `RST_START_VALUES);
    rd(`OFS_SEGMENT_CONFIG, 32'h0);
    apb(1'b1, `OFS_POSITION, 32'h3FF);
    rd(`OFS_POSITION, 32'h0);
    rd(32'h38, 32'h0);
    check("slverr", 32'(e), 32'h1);
    for (i = 0; i < 3; i++) step(0, 1'b0, 1);
    check("sine wave", 32'(coil_a_current_value[8:0]), 32'h4);
    for (i = 0; i < 3; i++) step(0, 1'b1, 1);
    check("sine reload", 32'(coil_b_current_value[8:0]), 32'hF7);
    $display("test reset done");
  endtask
  task t_table;
    for (i = 0; i < 8; i++) apb(1'b1, 32'(4 * i), 32'hFFFFFFFF);
    apb(1'b1, `OFS_START_VALUES, 32'h00200005);
    step(0, 1'b0, 1);
    step(0, 1'b0, 1);
    for (i = 0; i < 4; i++) begin
      apb(1'b1, `OFS_SEGMENT_CONFIG, {24'hFFFFFF, {4{i[1:0]}}});
      step(0, 1'b1, 1);
      step(0, 1'b1, 1);
      check("start a", 32'(coil_a_current_value[8:0]), 32'h5);
      check("start b", 32'(coil_b_current_value[8:0]), 32'h20);
      step(0, 1'b0, 1);
      step(0, 1'b0, 1);
      check("slope", 32'(coil_a_current_value[8:0]), 32'(5 + 2 * i));
    end
    apb(1'b1, `OFS_SEGMENT_CONFIG, 32'hFFFF0103);
    step(0, 1'b1, 1);
    step(0, 1'b1, 1);
    step(0, 1'b0, 1);
    step(0, 1'b0, 1);
    check("segment", 32'(coil_a_current_value[8:0]), 32'h8);
    $display("test table done");
  endtask
  task t_res;
    apb(1'b1, `OFS_RESOLUTION, 32'h00000021);
    rd(`OFS_RESOLUTION, 32'h00000021);
    step(0, 1'b0, 2);
    apb(1'b1, `OFS_RESOLUTION, 32'h00000020);
    check("position", 32'(pos[9:0]), 32'h4);
    step(0, 1'b0, 1);
    for (i = 0; i < 6; i++) step(0, 1'b1, 1);
    check("wrap", 32'(pos[9:0]), 32'h3FF);
    for (i = 0; i < 9; i++) step(0, 1'b0, 1);
    check("coarse start", 32'(pos[9:0]), 32'h8);
    apb(1'b1, `OFS_RESOLUTION, 32'h00000029);
    step(0, 1'b0, 256);
    step(1, 1'b0, 4);
    rd(`OFS_POSITION, 32'h00040108);
    step(1, 1'b1, 4);
    rd(`OFS_CURRENT_AXIS1, 32'h00200005);
    $display("test resolution done");
  endtask
  initial begin
    repeat (8) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    @(posedge clock_in);
    t_reset;
    t_table;
    t_res;
    stop_test;
  end
endmodule
`default_nettype wire
